// file: logic/crc_accel.sv
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
// How it works
// - core and dma share one input path
// - one control write sets enable and options
// - each word write advances checksum once
// - result upper bits msb-first, lower lsb-first
// - word consumed bit 31 down to 0
// - control bit 4 swaps halfwords
// - control bit 3 swaps bytes per half
// - control bit 2 reverses bits per byte
// - mirror options combine freely, all gives reversal
// - control bit 1 selects lsb-first order
// - control bit 0 enables the block
// - residual register n advances n bits
// - byte register advances exactly eight bits
// - polynomial resets to 32-bit ethernet value
module crc_accel
  import crc_accel_pkg::*;
#(
  // arbitrary value, carries no meaning
  parameter logic [3:0] REVISION = 4'h1
) (
  // clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_arst_n,
  // register port
  input  wire logic [crc_accel_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [crc_accel_pkg::DATA_W-1:0] i_wr_data,
  input  wire logic                        i_wr_en,
  input  wire logic                        i_rd_en,
  output logic      [crc_accel_pkg::DATA_W-1:0] o_rd_data,
  // status
  output logic                             o_active
);
  import crc_accel_pkg::*;

  // ****************************************************************
  // registers and decode
  // ****************************************************************
  logic [31:0] ctl_q;
  logic [31:0] poly_q;
  logic [31:0] result_q;
  logic [31:0] result_d;
  logic [31:0] rd_data_d;

  logic        hit_ctl;
  logic        hit_word;
  logic        hit_byte;
  logic        hit_poly;
  logic        hit_result;
  logic        hit_bits;
  logic [2:0]  bits_n;

  logic        en;
  logic        lsb_first;
  logic        feed_word;
  logic        feed_byte;
  logic        feed_bits;
  logic        feed_fire;

  logic [31:0] mirror_word;
  logic [7:0]  in_byte;
  logic [31:0] eng_data;
  logic [5:0]  eng_steps;
  logic        eng_from_low;
  logic [31:0] eng_crc;

  assign bits_n     = i_addr[4:2];
  assign hit_ctl    = (i_addr == OFS_CTL);
  // one input address serves core stores and dma stores alike
  assign hit_word   = (i_addr == OFS_WORD);
  assign hit_byte   = (i_addr == OFS_BYTE);
  assign hit_poly   = (i_addr == OFS_POLY);
  assign hit_result = (i_addr == OFS_RESULT);
  assign hit_bits   = ((i_addr & BITS_ADDR_MASK) == OFS_BITS_BASE)
                      && (bits_n != 3'h0);

  assign en        = ctl_q[CTL_EN_BIT];
  assign lsb_first = ctl_q[CTL_LSB_BIT];

  // input stores while disabled leave the residue untouched
  assign feed_word = i_wr_en && hit_word && en;
  assign feed_byte = i_wr_en && hit_byte && en;
  assign feed_bits = i_wr_en && hit_bits && en;
  assign feed_fire = feed_word || feed_byte || feed_bits;

  // ****************************************************************
  // data path
  // ****************************************************************
  crc_word_mirror u_mirror (
    .i_word     (i_wr_data),
    .i_hw_swap  (ctl_q[CTL_HWSWAP_BIT]),
    .i_byte_rev (ctl_q[CTL_BYTREV_BIT]),
    .i_bit_rev  (ctl_q[CTL_BITREV_BIT]),
    .o_word     (mirror_word)
  );

  // only bit mirroring applies to a byte; residual bits are never mirrored
  always_comb begin
    in_byte = i_wr_data[7:0];
    if (hit_byte && ctl_q[CTL_BITREV_BIT]) begin
      for (int i = 0; i < 8; i++) begin
        in_byte[i] = i_wr_data[7-i];
      end
    end
  end

  always_comb begin
    eng_data     = mirror_word;
    eng_steps    = WORD_STEPS;
    eng_from_low = 1'b0;
    if (!hit_word) begin
      // lsb-first bytes are consumed from bit 0 upward
      eng_from_low = lsb_first;
      eng_data     = lsb_first ? {24'h000000, in_byte}
                               : {in_byte, 24'h000000};
      eng_steps    = hit_bits ? {3'h0, bits_n}
                              : BYTE_STEPS;
    end
  end

  crc_serial_engine #(
    .W (DATA_W)
  ) u_engine (
    .i_crc       (result_q),
    .i_poly      (poly_q),
    .i_data      (eng_data),
    .i_steps     (eng_steps),
    .i_lsb_first (lsb_first),
    .i_from_low  (eng_from_low),
    .o_crc       (eng_crc)
  );

  // ****************************************************************
  // register updates
  // ****************************************************************
  // enable, order and all mirrors land in a single store
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctl_q <= CTL_RESET;
    end else if (i_wr_en && hit_ctl) begin
      ctl_q <= i_wr_data & CTL_RW_MASK;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      poly_q <= POLY_RESET;
    end else if (i_wr_en && hit_poly) begin
      poly_q <= i_wr_data;
    end
  end

  always_comb begin
    result_d = result_q;
    if (i_wr_en && hit_result) begin
      result_d = i_wr_data;
    end else if (feed_fire) begin
      result_d = eng_crc;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      result_q <= RESULT_RESET;
    end else begin
      result_q <= result_d;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // input registers are store-only and read as zero
  always_comb begin
    rd_data_d = 32'h00000000;
    if (i_rd_en) begin
      if (hit_ctl) begin
        rd_data_d = ctl_q;
        rd_data_d[CTL_REV_LSB +: CTL_REV_W] = REVISION;
      end else if (hit_poly) begin
        rd_data_d = poly_q;
      end else if (hit_result) begin
        rd_data_d = result_q;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= 32'h00000000;
    end else begin
      o_rd_data <= rd_data_d;
    end
  end

  // mirrors the enable so power control can gate the engine
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_active <= 1'b0;
    end else if (i_wr_en && hit_ctl) begin
      o_active <= i_wr_data[CTL_EN_BIT];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [31:0] full_rev;
  logic [2:0]  mirror_mode;
  logic [31:0] ref_short;
  logic [31:0] ref_word;
  logic [3:0]  ref_n;
  logic        ref_bit;
  logic        ref_fb;
  logic        ref_wfb;

  assign mirror_mode = ctl_q[CTL_HWSWAP_BIT:CTL_BITREV_BIT];

  always_comb begin
    full_rev = 32'h00000000;
    for (int i = 0; i < 32; i++) begin
      full_rev[i] = i_wr_data[31-i];
    end
  end

  // bit-serial models written apart from the engine, so a slip in the
  // unrolled loop cannot hide behind a shared expression
  always_comb begin
    ref_short = result_q;
    ref_bit   = 1'b0;
    ref_fb    = 1'b0;
    ref_n     = hit_bits ? {1'b0, bits_n} : 4'h8;
    for (int k = 0; k < 8; k++) begin
      if (4'(k) < ref_n) begin
        ref_bit   = lsb_first ? in_byte[k] : in_byte[7-k];
        ref_fb    = ref_bit ^ (lsb_first ? ref_short[0] : ref_short[31]);
        ref_short = lsb_first ? (ref_short >> 1) : (ref_short << 1);
        if (ref_fb) begin
          ref_short = ref_short ^ poly_q;
        end
      end
    end
  end

  always_comb begin
    ref_word = result_q;
    ref_wfb  = 1'b0;
    for (int k = 31; k >= 0; k--) begin
      ref_wfb  = mirror_word[k] ^ (lsb_first ? ref_word[0] : ref_word[31]);
      ref_word = lsb_first ? (ref_word >> 1) : (ref_word << 1);
      if (ref_wfb) begin
        ref_word = ref_word ^ poly_q;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  ctl_write_a: assert property (
    i_wr_en && hit_ctl |=> ctl_q == ($past(i_wr_data) & CTL_RW_MASK)
      && o_active == ctl_q[CTL_EN_BIT])
    else $error("control store not taken in one cycle");

  revision_ro_a: assert property (
    i_rd_en && hit_ctl |=> o_rd_data[31:28] == REVISION)
    else $error("revision field not read-only");

  input_gated_a: assert property (
    i_wr_en && (hit_word || hit_byte || hit_bits) && !en
      |=> $stable(result_q))
    else $error("disabled input changed the residue");

  result_cause_a: assert property (
    !(i_wr_en && (hit_result || feed_fire)) |=> $stable(result_q))
    else $error("residue moved without a store");

  seed_load_a: assert property (
    i_wr_en && hit_result |=> result_q == $past(i_wr_data))
    else $error("seed not loaded");

  rd_idle_a: assert property (
    !i_rd_en |=> o_rd_data == 32'h00000000)
    else $error("read data outside its cycle");

  rd_result_a: assert property (
    i_rd_en && hit_result |=> o_rd_data == $past(result_q))
    else $error("result read mismatch");

  full_reverse_a: assert property (
    mirror_mode == 3'h7 |-> mirror_word == full_rev)
    else $error("all mirrors do not fully reverse");

  pass_through_a: assert property (
    mirror_mode == 3'h0 |-> mirror_word == i_wr_data)
    else $error("no mirror must pass word unchanged");

  msb_one_bit_a: assert property (
    feed_bits && bits_n == 3'h1 && !lsb_first
      |=> result_q == (($past(result_q) << 1)
        ^ (($past(result_q[31]) ^ $past(i_wr_data[7]))
           ? $past(poly_q) : 32'h00000000)))
    else $error("msb-first single residual bit wrong");

  lsb_one_bit_a: assert property (
    feed_bits && bits_n == 3'h1 && lsb_first
      |=> result_q == (($past(result_q) >> 1)
        ^ (($past(result_q[0]) ^ $past(i_wr_data[0]))
           ? $past(poly_q) : 32'h00000000)))
    else $error("lsb-first single residual bit wrong");

  poly_load_a: assert property (
    i_wr_en && hit_poly |=> poly_q == $past(i_wr_data))
    else $error("polynomial store not taken");

  active_match_a: assert property (
    o_active == ctl_q[CTL_EN_BIT])
    else $error("active flag differs from enable");

  rd_ctl_a: assert property (
    i_rd_en && hit_ctl |=> o_rd_data[27:0] == $past(ctl_q[27:0]))
    else $error("control read mismatch");

  rd_poly_a: assert property (
    i_rd_en && hit_poly |=> o_rd_data == $past(poly_q))
    else $error("polynomial read mismatch");

  rd_input_a: assert property (
    i_rd_en && (hit_word || hit_byte || hit_bits)
      |=> o_rd_data == 32'h00000000)
    else $error("input register did not read as zero");

  short_feed_a: assert property (
    feed_byte || feed_bits |=> result_q == $past(ref_short))
    else $error("byte or residual store advanced wrongly");

  word_step_a: assert property (
    feed_word |=> result_q == $past(ref_word))
    else $error("word store advanced wrongly");

  word_cov: cover property (feed_word ##1 i_rd_en && hit_result);
  byte_cov: cover property (feed_byte && lsb_first);
  bits_cov: cover property (feed_bits && bits_n == 3'h7);
  mirror_cov: cover property (feed_word && mirror_mode == 3'h7);
  off_cov: cover property (i_wr_en && hit_word && !en);

endmodule : crc_accel

// file: logic/crc_accel_pkg.sv
package crc_accel_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam logic [7:0]  OFS_CTL        = 8'h00;
  localparam logic [7:0]  OFS_WORD       = 8'h04;
  localparam logic [7:0]  OFS_BYTE       = 8'h08;
  localparam logic [7:0]  OFS_POLY       = 8'h0C;
  localparam logic [7:0]  OFS_RESULT     = 8'h10;
  // residual input n sits at OFS_BITS_BASE + 4*n, n = 1..7
  localparam logic [7:0]  OFS_BITS_BASE  = 8'h20;
  localparam logic [7:0]  BITS_ADDR_MASK = 8'hE3;

  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int          CTL_EN_BIT     = 0;
  localparam int          CTL_LSB_BIT    = 1;
  localparam int          CTL_BITREV_BIT = 2;
  localparam int          CTL_BYTREV_BIT = 3;
  localparam int          CTL_HWSWAP_BIT = 4;
  localparam int          CTL_REV_LSB    = 28;
  localparam int          CTL_REV_W      = 4;
  localparam logic [31:0] CTL_RW_MASK    = 32'h0000001F;

  // ****************************************************************
  // reset values and step counts
  // ****************************************************************
  localparam logic [31:0] CTL_RESET      = 32'h00000000;
  localparam logic [31:0] POLY_RESET     = 32'h04C11DB7;
  localparam logic [31:0] RESULT_RESET   = 32'h00000000;
  localparam logic [5:0]  WORD_STEPS     = 6'h20;
  localparam logic [5:0]  BYTE_STEPS     = 6'h08;

endpackage : crc_accel_pkg

// file: logic/crc_word_mirror.sv
`timescale 1ns/1ps
module crc_word_mirror (
  // raw word and options
  input  wire logic [31:0] i_word,
  input  wire logic        i_hw_swap,
  input  wire logic        i_byte_rev,
  input  wire logic        i_bit_rev,
  // reordered word
  output logic      [31:0] o_word
);
  logic [31:0] swap_w;
  logic [31:0] byte_w;

  // the three stages commute, so all eight settings combine freely
  always_comb begin
    swap_w = i_hw_swap ? {i_word[15:0], i_word[31:16]} : i_word;
    byte_w = i_byte_rev ? {swap_w[23:16], swap_w[31:24],
                           swap_w[7:0], swap_w[15:8]} : swap_w;
    o_word = byte_w;
    if (i_bit_rev) begin
      for (int i = 0; i < 32; i++) begin
        o_word[i] = byte_w[(i & 24) + 7 - (i & 7)];
      end
    end
  end

endmodule : crc_word_mirror

// file: logic/crc_serial_engine.sv
`timescale 1ns/1ps
module crc_serial_engine #(
  parameter int W = 32
) (
  // running state
  input  wire logic [W-1:0] i_crc,
  input  wire logic [W-1:0] i_poly,
  // data and step control
  input  wire logic [W-1:0] i_data,
  input  wire logic [5:0]   i_steps,
  input  wire logic         i_lsb_first,
  input  wire logic         i_from_low,
  // advanced state
  output logic      [W-1:0] o_crc
);
  logic [W-1:0] seq;
  logic [W-1:0] crc;
  logic         fb;

  // all steps unrolled into one cycle so the bus never has to wait
  always_comb begin
    seq = i_data;
    crc = i_crc;
    fb  = 1'b0;
    if (i_from_low) begin
      for (int i = 0; i < W; i++) begin
        seq[i] = i_data[W-1-i];
      end
    end
    for (int i = 0; i < W; i++) begin
      if (6'(i) < i_steps) begin
        if (i_lsb_first) begin
          fb  = crc[0] ^ seq[W-1-i];
          crc = crc >> 1;
        end else begin
          fb  = crc[W-1] ^ seq[W-1-i];
          crc = crc << 1;
        end
        if (fb) begin
          crc = crc ^ i_poly;
        end
      end
    end
    o_crc = crc;
  end

endmodule : crc_serial_engine

// file: bench/crc_dma_model.sv
`timescale 1ns/1ps
module crc_dma_model (
  // clock and command
  input  wire logic        i_clk,
  input  wire logic        i_start,
  input  wire logic        i_slow,
  input  wire logic [31:0] i_words [4],
  // bus side
  output logic      [7:0]  o_addr,
  output logic      [31:0] o_wr_data,
  output logic             o_wr_en,
  output logic             o_done
);
  import crc_accel_pkg::*;
  // ******************************
  // channel with fixed target
  // ******************************
  assign o_addr = OFS_WORD; // word size, no increment
  initial begin
    o_wr_data = 32'h0;
    o_wr_en   = 1'b0;
    o_done    = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_start) begin
        for (int k = 0; k < 4; k++) begin
          o_wr_data <= i_words[k]; // same path as core writes
          o_wr_en   <= 1'b1;
          @(posedge i_clk);
          if (i_slow) begin
            // released data must not look like a held value
            o_wr_en   <= 1'b0;
            o_wr_data <= ~i_words[k];
            repeat (2) @(posedge i_clk);
          end
        end
        o_wr_en   <= 1'b0;
        o_wr_data <= ~o_wr_data;
        @(posedge i_clk);
        o_done <= 1'b1; // only after the last write
        @(posedge i_clk);
        o_done <= 1'b0;
      end
    end
  end
endmodule : crc_dma_model

// file: bench/crc_accelerator_mirroring_test.sv
`timescale 1ns/1ps
module crc_accelerator_mirroring_test;
  import crc_accel_pkg::*;
  localparam logic [3:0] REV = 4'hA; // arbitrary value
  logic        clk, rst_n, b_wr, b_rd, d_wr, d_sel, d_start, d_slow, d_done;
  logic        active;
  logic [7:0]  b_addr, d_addr;
  logic [31:0] b_data, d_data, rd_data, e, poly, ctl, v;
  logic [31:0] d_words [4];
  int          error_cnt, checks, cyc, n;

  crc_accel #(.REVISION(REV)) i_dut (
    .i_clk_sys(clk), .i_arst_n(rst_n),
    .i_addr(d_sel ? d_addr : b_addr), .i_wr_data(d_sel ? d_data : b_data),
    .i_wr_en(b_wr | (d_sel & d_wr)), .i_rd_en(b_rd),
    .o_rd_data(rd_data), .o_active(active));
  crc_dma_model i_dma (
    .i_clk(clk), .i_start(d_start), .i_slow(d_slow), .i_words(d_words),
    .o_addr(d_addr), .o_wr_data(d_data), .o_wr_en(d_wr), .o_done(d_done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ******************************
  // reference model
  // ******************************
  function automatic logic [31:0] mir(logic [31:0] w, logic [4:0] c);
    logic [31:0] r, t;
    r = c[4] ? {w[15:0], w[31:16]} : w;
    if (c[3]) r = {r[23:16], r[31:24], r[7:0], r[15:8]};
    t = r;
    if (c[2]) for (int i = 0; i < 32; i++) r[i] = t[i ^ 7];
    return r;
  endfunction : mir
  function automatic logic [31:0] feed(logic [31:0] c, logic [31:0] d,
                                       int cnt, int top, bit up, bit lsb);
    logic b, fb;
    for (int k = 0; k < cnt; k++) begin
      b  = up ? d[k] : d[top-k];
      fb = lsb ? c[0] ^ b : c[31] ^ b;
      c  = lsb ? c >> 1 : c << 1;
      if (fb) c = c ^ poly;
    end
    return c;
  endfunction : feed
  // ******************************
  // bus tasks
  // ******************************
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    b_addr <= a;
    b_data <= d;
    b_wr   <= 1'b1;
    @(posedge clk);
    b_wr   <= 1'b0;
    b_data <= ~d;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    b_addr <= a;
    b_rd   <= 1'b1;
    @(posedge clk);
    b_rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task automatic complete_run();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // ******************************
  // scenarios
  // ******************************
  initial begin
    {rst_n, b_wr, b_rd, d_sel, d_start, d_slow} = '0;
    b_addr = 8'h00;
    b_data = 32'h0;
    d_words = '{32'h0000_0001, 32'hFFFF_0000, 32'h1234_5678, 32'h8000_0001};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_CTL, v); chk("ctl reset", v, {REV, 28'h0});
    rd(OFS_POLY, v); chk("poly reset", v, 32'h04C1_1DB7);
    for (int o = 0; o < 2; o++) for (int m = 0; m < 8; m++) begin
      ctl  = {27'h0, m[2:0], o[0], 1'b1};
      poly = o ? 32'h0000_8408 : 32'h1021_0000;
      e    = o ? 32'h0000_FFFF : 32'hFFFF_0000;
      n    = (m % 7) + 1;
      wr(OFS_POLY, poly);
      wr(OFS_RESULT, e);
      wr(OFS_CTL, ctl);
      #1 chk("active", {31'h0, active}, 32'h1);
      rd(OFS_CTL, v); chk("ctl", v, {REV, 23'h0, ctl[4:0]});
      v = 32'hA5C3_0F96 ^ {m[2:0], o[0]};
      wr(OFS_WORD, v);
      e = feed(e, mir(v, ctl[4:0]), 32, 31, 0, o[0]);
      wr(OFS_BYTE, {24'h0, v[7:0]});
      e = feed(e, mir(v, {2'b0, ctl[2], 2'b0}), 8, 7, o[0], o[0]);
      wr(OFS_BITS_BASE + 8'(4 * n), {24'h0, v[15:8]});
      e = feed(e, {24'h0, v[15:8]}, n, 7, o[0], o[0]);
      rd(OFS_RESULT, v); chk("crc", v, e);
      chk("mode", v, e);
      chk("idle half", o ? v >> 16 : v << 16, 32'h0);
    end
    wr(OFS_CTL, 32'hFFFF_FFFF);
    rd(OFS_CTL, v); chk("ctl ro", v, {REV, 23'h0, 5'h1F});
    wr(OFS_CTL, 32'h0);
    #1 chk("inactive", {31'h0, active}, 32'h0);
    wr(OFS_WORD, 32'h55AA_33CC);
    wr(OFS_BYTE, 32'h0000_00C3);
    wr(OFS_BITS_BASE + 8'h0C, 32'h0000_00E0);
    rd(OFS_RESULT, v); chk("disabled", v, e);
    rd(8'h40, v); chk("unmapped", v, 32'h0);
    rd(OFS_WORD, v); chk("word rd", v, 32'h0);
    @(posedge clk);
    #1 chk("rd idle", rd_data, 32'h0);
    poly = 32'h04C1_1DB7;
    for (int s = 0; s < 2; s++) begin
      ctl = s ? 32'h1D : 32'h1;
      e   = 32'hFFFF_FFFF;
      wr(OFS_POLY, poly);
      wr(OFS_RESULT, e);
      wr(OFS_CTL, ctl);
      for (int k = 0; k < 4; k++) e = feed(e, mir(d_words[k], ctl[4:0]),
                                           32, 31, 0, 0);
      @(posedge clk);
      d_sel   <= 1'b1;
      d_slow  <= s[0];
      d_start <= 1'b1;
      @(posedge clk);
      d_start <= 1'b0;
      repeat (60) begin
        @(posedge clk);
        if (d_done === 1'b1) break;
      end
      chk("dma done", {31'h0, d_done}, 32'h1);
      d_sel <= 1'b0;
      rd(OFS_RESULT, v); chk("dma crc", v, e);
    end
    complete_run();
  end
endmodule : crc_accelerator_mirroring_test
